// file: verilog/rtcc_pkg.sv
// Package of constants and types for the real-time clock time counters.
package rtcc_pkg;

  // ----------------------------------------------------------------------
  // Clock rates and timing counts
  // ----------------------------------------------------------------------
  localparam int unsigned MCLK_HZ = 250000000;
  localparam int unsigned TICK_HZ = 256;
  // Cycles of mclk in one 1/256 s period, rounded down.
  localparam int unsigned TICK_CYCLES = MCLK_HZ / TICK_HZ;
  localparam int PRE_W = 20;
  localparam int PADDR_W = 17;
  localparam int IDX_W = 15;

  // ----------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_MAIN_CTRL = 15'h5142;
  localparam logic [IDX_W-1:0] IDX_HOLD_CTRL = 15'h5143;
  localparam logic [IDX_W-1:0] IDX_SECONDS = 15'h5144;
  localparam logic [IDX_W-1:0] IDX_MINUTES = 15'h5145;
  localparam logic [IDX_W-1:0] IDX_HOURS = 15'h5146;
  localparam logic [IDX_W-1:0] IDX_DAYS = 15'h5147;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTL_RST_BIT = 0;
  localparam int CTL_STP_BIT = 1;
  localparam int CTL_ADJ_BIT = 2;
  localparam int CTL_24H_BIT = 4;
  localparam int HLD_HOLD_BIT = 0;
  localparam int HLD_BUSY_BIT = 1;
  localparam int HR_PM_BIT = 6;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RST_RUN_STOP = 1'h1;
  localparam logic [1:0] RST_HOURS_TENS = 2'h1;
  localparam logic [3:0] RST_HOURS_UNITS = 4'h2;
  localparam logic [3:0] RST_DAYS_UNITS = 4'h1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RTCC_ADJ_IDLE = 3'h1,
    RTCC_ADJ_WAIT = 3'h2,
    RTCC_ADJ_RUN = 3'h4
  } rtcc_adj_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } rtcc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rtcc_apb_rsp_s;

  typedef struct packed {
    logic [PRE_W-1:0] pre_cnt;
    logic [7:0] sub;
    logic [PRE_W-1:0] busy_cnt;
    rtcc_adj_e adj;
    logic counter_run_stop;
    logic hour_format_select;
    logic counter_hold;
    logic hold_pend;
    logic [3:0] seconds_units;
    logic [2:0] seconds_tens;
    logic [3:0] minutes_units;
    logic [2:0] minutes_tens;
    logic [3:0] hours_units;
    logic [1:0] hours_tens;
    logic meridian_indicator;
    logic [3:0] days_units;
    logic [1:0] days_tens;
    logic month_carry;
    rtcc_apb_rsp_s rsp;
  } rtcc_state_s;

endpackage : rtcc_pkg

// file: verilog/rtcc_bcd_digit.sv
// One BCD counter digit with wrap and carry out.
`timescale 1ns/1ps
module rtcc_bcd_digit #(
  parameter int W = 4
)
(
  // Present digit and step request.
  input wire logic [W-1:0] value,
  input wire logic inc,
  // Last value before the wrap, and the value the wrap loads.
  input wire logic [W-1:0] top,
  input wire logic [W-1:0] wrap,
  // Stepped digit and carry to the next digit.
  output logic [W-1:0] next_value,
  output logic carry
);

  // Steps the digit; an out-of-range value also wraps.
  always_comb
  begin
    next_value = value;
    carry = 1'b0;
    if (inc)
    begin
      if (value >= top)
      begin
        next_value = wrap;
        carry = 1'b1;
      end
      else
      begin
        next_value = value + W'(1);
      end
    end
  end

endmodule : rtcc_bcd_digit

// file: verilog/rtcc_time_counters.sv
// Real-time clock control and BCD time-of-day counters with an APB slave.
// Summary of operation
// - Hour format bit picks 24 or 12 hour range; stored hours stay.
// - Writing 1 starts thirty-second adjust; bit reads 1 until done.
// - Adjust clears seconds; adds a minute when seconds were 30 to 59.
// - Run/stop 1 freezes divider and counters; 256 Hz base keeps going.
// - Soft reset clears sub-second divider, adjust and hold; self clears.
// - Busy flag reads 1 for 1/256 s after every carry event.
// - Hold blocks seconds carry; one second added on release if missed.
// - Hold ignores writes of 1 while busy reads 1.
// - Seconds units count 0 to 9 on the 1 s tick, carry on wrap.
// - Seconds tens count 0 to 5, carry into minutes units.
// - Minutes units 0 to 9, minutes tens 0 to 5, carry into hours.
// - Hours wrap at 12 or 24 by format and carry into days.
// - Meridian reads PM in 12 hour mode; 0 in 24 hour mode.
// - Meridian keeps old value after format change until hour update.
// - Days count BCD, return to 01 at month end, carry to month.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module rtcc_time_counters #(
  parameter int unsigned TICK_CYCLES = rtcc_pkg::TICK_CYCLES
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // APB register port.
  input wire rtcc_pkg::rtcc_apb_req_s apb_req,
  output rtcc_pkg::rtcc_apb_rsp_s apb_rsp,
  // Month side: last day of the current month, carry out to the month.
  input wire logic [5:0] month_last_day,
  output logic month_carry
);

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  localparam logic [rtcc_pkg::PRE_W-1:0] TICK_LAST =
    rtcc_pkg::PRE_W'(TICK_CYCLES - 1);

  rtcc_pkg::rtcc_state_s st;
  rtcc_pkg::rtcc_state_s next_st;
  logic [rtcc_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic wr;
  logic wr_main;
  logic wr_hold;
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_day;
  logic tick;
  logic sec_tick;
  logic busy;
  logic hold_release;
  logic adj_apply;
  logic adj_add_min;
  logic sec_inc;
  logic [3:0] su_next;
  logic [2:0] st_next;
  logic [3:0] mu_next;
  logic [2:0] mt_next;
  logic su_carry;
  logic st_carry;
  logic mu_carry;
  logic hr_inc;

  // Bus decode; a write takes effect in the access cycle with pready.
  assign idx = apb_req.paddr[rtcc_pkg::PADDR_W-1:2];
  assign aligned = apb_req.paddr[1:0] == 2'h0;
  assign wr = apb_req.psel & apb_req.penable & st.rsp.pready &
    apb_req.pwrite & aligned;
  assign wr_main = wr & (idx == rtcc_pkg::IDX_MAIN_CTRL);
  assign wr_hold = wr & (idx == rtcc_pkg::IDX_HOLD_CTRL);
  assign wr_sec = wr & (idx == rtcc_pkg::IDX_SECONDS);
  assign wr_min = wr & (idx == rtcc_pkg::IDX_MINUTES);
  assign wr_hour = wr & (idx == rtcc_pkg::IDX_HOURS);
  assign wr_day = wr & (idx == rtcc_pkg::IDX_DAYS);

  // Timing events: the 256 Hz base never stops, the 1 s tick does.
  assign tick = st.pre_cnt == TICK_LAST;
  assign sec_tick = tick & ~st.counter_run_stop & (st.sub == 8'hff);
  assign busy = st.busy_cnt != '0;
  assign hold_release = wr_hold & ~apb_req.pwdata[rtcc_pkg::HLD_HOLD_BIT] &
    (st.hold_pend | (sec_tick & st.counter_hold));
  assign adj_apply = (st.adj == rtcc_pkg::RTCC_ADJ_WAIT) & ~busy;
  assign adj_add_min = adj_apply & (st.seconds_tens >= 3'h3);
  assign sec_inc = (sec_tick & ~st.counter_hold) | hold_release;

  // ----------------------------------------------------------------------
  // Seconds and minutes digit chain
  // ----------------------------------------------------------------------
  // Seconds units step on the 1 s tick.
  rtcc_bcd_digit #(.W(4)) u_sec_units (
    .value(st.seconds_units),
    .inc(sec_inc),
    .top(4'h9),
    .wrap(4'h0),
    .next_value(su_next),
    .carry(su_carry)
  );

  // Seconds tens step on units carry.
  rtcc_bcd_digit #(.W(3)) u_sec_tens (
    .value(st.seconds_tens),
    .inc(su_carry),
    .top(3'h5),
    .wrap(3'h0),
    .next_value(st_next),
    .carry(st_carry)
  );

  // Minutes units step on seconds carry or the rounding adjust.
  rtcc_bcd_digit #(.W(4)) u_min_units (
    .value(st.minutes_units),
    .inc(st_carry | adj_add_min),
    .top(4'h9),
    .wrap(4'h0),
    .next_value(mu_next),
    .carry(mu_carry)
  );

  // Minutes tens carry into the hours.
  rtcc_bcd_digit #(.W(3)) u_min_tens (
    .value(st.minutes_tens),
    .inc(mu_carry),
    .top(3'h5),
    .wrap(3'h0),
    .next_value(mt_next),
    .carry(hr_inc)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Computes every field of the next state from the present one.
  always_comb
  begin
    logic [5:0] hr;
    logic [5:0] dy;
    logic day_inc;
    logic [7:0] rd;
    hr = {st.hours_tens, st.hours_units};
    dy = {st.days_tens, st.days_units};
    day_inc = 1'b0;
    rd = 8'h00;
    next_st = st;
    next_st.month_carry = 1'b0;

    // Free-running 256 Hz base and the stoppable sub-second divider.
    next_st.pre_cnt = tick ? '0 : st.pre_cnt + rtcc_pkg::PRE_W'(1);
    if (tick & ~st.counter_run_stop)
    begin
      next_st.sub = st.sub + 8'h01;
    end

    // Busy count-down; a new carry event reloads it and wins.
    if (busy)
    begin
      next_st.busy_cnt = st.busy_cnt - rtcc_pkg::PRE_W'(1);
    end
    if (sec_inc | adj_apply)
    begin
      next_st.busy_cnt = rtcc_pkg::PRE_W'(TICK_CYCLES);
    end

    // Hold: blocked second carries are remembered once.
    if (sec_tick & st.counter_hold)
    begin
      next_st.hold_pend = 1'b1;
    end
    if (hold_release)
    begin
      next_st.hold_pend = 1'b0;
    end

    // Seconds and minutes digits.
    next_st.seconds_units = su_next;
    next_st.seconds_tens = st_next;
    next_st.minutes_units = mu_next;
    next_st.minutes_tens = mt_next;
    if (adj_apply)
    begin
      next_st.seconds_units = 4'h0;
      next_st.seconds_tens = 3'h0;
    end

    // Hours step and wrap per format.
    if (hr_inc)
    begin
      if (st.hour_format_select)
      begin
        next_st.meridian_indicator = 1'b0;
        if (hr >= 6'h23)
        begin
          hr = 6'h00;
          day_inc = 1'b1;
        end
        else if (st.hours_units >= 4'h9)
        begin
          hr = {st.hours_tens + 2'h1, 4'h0};
        end
        else
        begin
          hr = hr + 6'h01;
        end
      end
      else
      begin
        if (hr >= 6'h12)
        begin
          hr = 6'h01;
        end
        else if (hr == 6'h11)
        begin
          hr = 6'h12;
          next_st.meridian_indicator = ~st.meridian_indicator;
          day_inc = st.meridian_indicator;
        end
        else if (st.hours_units >= 4'h9)
        begin
          hr = {st.hours_tens + 2'h1, 4'h0};
        end
        else
        begin
          hr = hr + 6'h01;
        end
      end
      next_st.hours_tens = hr[5:4];
      next_st.hours_units = hr[3:0];
    end

    // Days return to 01 at month end and carry to the month.
    if (day_inc)
    begin
      if (dy >= month_last_day)
      begin
        dy = {2'h0, rtcc_pkg::RST_DAYS_UNITS};
        next_st.month_carry = 1'b1;
      end
      else if (st.days_units >= 4'h9)
      begin
        dy = {st.days_tens + 2'h1, 4'h0};
      end
      else
      begin
        dy = dy + 6'h01;
      end
      next_st.days_tens = dy[5:4];
      next_st.days_units = dy[3:0];
    end

    // Thirty-second adjust sequence; bit reads 1 until it ends.
    case (st.adj)
      rtcc_pkg::RTCC_ADJ_IDLE:
      begin
        if (wr_main & apb_req.pwdata[rtcc_pkg::CTL_ADJ_BIT])
        begin
          next_st.adj = rtcc_pkg::RTCC_ADJ_WAIT;
        end
      end
      rtcc_pkg::RTCC_ADJ_WAIT:
      begin
        if (adj_apply)
        begin
          next_st.adj = rtcc_pkg::RTCC_ADJ_RUN;
        end
      end
      rtcc_pkg::RTCC_ADJ_RUN:
      begin
        if (st.busy_cnt == rtcc_pkg::PRE_W'(1))
        begin
          next_st.adj = rtcc_pkg::RTCC_ADJ_IDLE;
        end
      end
      default:
      begin
        next_st.adj = rtcc_pkg::RTCC_ADJ_IDLE;
      end
    endcase

    // Main control writes; format change leaves hours alone.
    if (wr_main)
    begin
      next_st.hour_format_select = apb_req.pwdata[rtcc_pkg::CTL_24H_BIT];
      next_st.counter_run_stop = apb_req.pwdata[rtcc_pkg::CTL_STP_BIT];
      if (apb_req.pwdata[rtcc_pkg::CTL_RST_BIT])
      begin
        next_st.sub = 8'h00;
        next_st.adj = rtcc_pkg::RTCC_ADJ_IDLE;
        next_st.counter_hold = 1'b0;
        next_st.hold_pend = 1'b0;
        if (st.hour_format_select)
        begin
          next_st.meridian_indicator = 1'b0;
        end
      end
    end

    // Hold writes; setting is refused while busy.
    if (wr_hold)
    begin
      next_st.counter_hold = apb_req.pwdata[rtcc_pkg::HLD_HOLD_BIT] & ~busy;
    end

    // Counter writes load the digits directly.
    if (wr_sec)
    begin
      next_st.seconds_tens = apb_req.pwdata[6:4];
      next_st.seconds_units = apb_req.pwdata[3:0];
    end
    if (wr_min)
    begin
      next_st.minutes_tens = apb_req.pwdata[6:4];
      next_st.minutes_units = apb_req.pwdata[3:0];
    end
    if (wr_hour)
    begin
      next_st.hours_tens = apb_req.pwdata[5:4];
      next_st.hours_units = apb_req.pwdata[3:0];
      next_st.meridian_indicator = apb_req.pwdata[rtcc_pkg::HR_PM_BIT] &
        ~st.hour_format_select;
    end
    if (wr_day)
    begin
      next_st.days_tens = apb_req.pwdata[5:4];
      next_st.days_units = apb_req.pwdata[3:0];
    end

    // Read data captured in the setup cycle; reserved bits are 0.
    case (idx)
      rtcc_pkg::IDX_MAIN_CTRL: rd = {3'h0, st.hour_format_select, 1'b0,
        st.adj != rtcc_pkg::RTCC_ADJ_IDLE, st.counter_run_stop, 1'b0};
      rtcc_pkg::IDX_HOLD_CTRL: rd = {6'h00, busy, st.counter_hold};
      rtcc_pkg::IDX_SECONDS: rd = {1'b0, st.seconds_tens, st.seconds_units};
      rtcc_pkg::IDX_MINUTES: rd = {1'b0, st.minutes_tens, st.minutes_units};
      rtcc_pkg::IDX_HOURS: rd = {1'b0, st.meridian_indicator,
        st.hours_tens, st.hours_units};
      rtcc_pkg::IDX_DAYS: rd = {2'h0, st.days_tens, st.days_units};
      default: rd = 8'h00;
    endcase
    next_st.rsp.pready = apb_req.psel & ~apb_req.penable;
    if (apb_req.psel & ~apb_req.penable)
    begin
      next_st.rsp.prdata = aligned ? {24'h000000, rd} : 32'h00000000;
      next_st.rsp.pslverr = ~aligned | (idx < rtcc_pkg::IDX_MAIN_CTRL) |
        (idx > rtcc_pkg::IDX_DAYS);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Registers the whole state; reset loads the documented values.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.adj <= rtcc_pkg::RTCC_ADJ_IDLE;
      st.counter_run_stop <= rtcc_pkg::RST_RUN_STOP;
      st.hours_tens <= rtcc_pkg::RST_HOURS_TENS;
      st.hours_units <= rtcc_pkg::RST_HOURS_UNITS;
      st.days_units <= rtcc_pkg::RST_DAYS_UNITS;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign apb_rsp = st.rsp;
  assign month_carry = st.month_carry;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_fmt_keeps_hours: assert property (
    wr_main & ~hr_inc & ~wr_hour |=> st.hours_tens == $past(st.hours_tens) &&
      st.hours_units == $past(st.hours_units))
    else $error("Hour value changed on a format write.");
  a_adj_reads_one: assert property (
    wr_main & apb_req.pwdata[rtcc_pkg::CTL_ADJ_BIT] &
      ~apb_req.pwdata[rtcc_pkg::CTL_RST_BIT] |=>
      st.adj != rtcc_pkg::RTCC_ADJ_IDLE)
    else $error("Adjust bit did not read one after start.");
  a_adj_rounds: assert property (
    adj_apply & ~wr_sec & ~wr_min & st.seconds_tens >= 3'h3 &
      st.minutes_units < 4'h9 |=>
      st.seconds_units == 4'h0 && st.seconds_tens == 3'h0 &&
      st.minutes_units == $past(st.minutes_units) + 4'h1)
    else $error("Adjust did not round seconds up.");
  a_stop_freezes: assert property (
    st.counter_run_stop & ~wr_main |=> $stable(st.sub))
    else $error("Divider moved while stopped.");
  a_soft_reset: assert property (
    wr_main & apb_req.pwdata[rtcc_pkg::CTL_RST_BIT] |=>
      st.sub == 8'h00 && !st.counter_hold &&
      st.adj == rtcc_pkg::RTCC_ADJ_IDLE)
    else $error("Soft reset did not clear divider and controls.");
  a_busy_on_carry: assert property (
    sec_inc |=> busy && st.busy_cnt == rtcc_pkg::PRE_W'(TICK_CYCLES))
    else $error("Busy not loaded on a seconds count.");
  a_hold_blocks: assert property (
    sec_tick & st.counter_hold & ~wr_sec & ~wr_main & ~adj_apply &
      ~hold_release |=> $stable(st.seconds_units) && st.hold_pend)
    else $error("Seconds moved while held.");
  a_hold_refused: assert property (
    wr_hold & busy & ~st.counter_hold |=> !st.counter_hold)
    else $error("Hold was set while busy.");
  a_sec_wraps: assert property (
    sec_inc & st.seconds_units == 4'h9 & ~wr_sec & ~adj_apply |=>
      st.seconds_units == 4'h0)
    else $error("Seconds units did not wrap after nine.");
  a_pm_in_24h: assert property (
    hr_inc & st.hour_format_select & ~wr_hour |=> !st.meridian_indicator)
    else $error("Meridian not cleared in 24 hour mode.");

  c_second_count: cover property (sec_inc ##1 busy);
  c_adjust_run: cover property (adj_apply ##1
    st.adj == rtcc_pkg::RTCC_ADJ_RUN);
  c_hold_release: cover property (hold_release);
  c_month_carry: cover property (st.month_carry);

endmodule : rtcc_time_counters

// file: sim/rtcc_time_counters_tb_top.sv
// Self-checking testbench for the real-time clock time counters.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module rtcc_time_counters_tb_top;
  // ----------------------------------------------------------------------
  // Constants and signals
  // ----------------------------------------------------------------------
  localparam int TC = 8;
  localparam int SEC = 256 * TC;
  localparam int LIMIT = 60000;
  localparam logic [14:0] I_CTL = rtcc_pkg::IDX_MAIN_CTRL;
  localparam logic [14:0] I_HLD = rtcc_pkg::IDX_HOLD_CTRL;
  localparam logic [14:0] I_SEC = rtcc_pkg::IDX_SECONDS;
  localparam logic [14:0] I_MIN = rtcc_pkg::IDX_MINUTES;
  localparam logic [14:0] I_HR = rtcc_pkg::IDX_HOURS;
  localparam logic [14:0] I_DAY = rtcc_pkg::IDX_DAYS;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  rtcc_pkg::rtcc_apb_req_s req = '0;
  rtcc_pkg::rtcc_apb_rsp_s rsp;
  logic [5:0] last_day = 6'h31;
  logic mcarry;
  logic [31:0] rd;
  logic er;
  logic [7:0] v;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int mc_cnt = 0;
  int n;
  integer seed;

  // Clock of 4 ns period.
  always #2 mclk = ~mclk;

  // Device under test with a short base tick.
  rtcc_time_counters #(.TICK_CYCLES(TC)) dut (
    .mclk(mclk),
    .rst(rst),
    .apb_req(req),
    .apb_rsp(rsp),
    .month_last_day(last_day),
    .month_carry(mcarry)
  );

  // Cycle ceiling and month carry pulse counter.
  always @(posedge mclk)
  begin
    cyc++;
    if (mcarry === 1'b1)
      mc_cnt++;
    if (cyc == LIMIT)
    begin
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [16:0] addr(input logic [14:0] idx);
    addr = {idx, 2'b00};
  endfunction : addr

  function automatic logic [7:0] bcd(input int x);
    bcd = 8'((x / 10) * 16 + x % 10);
  endfunction : bcd

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [16:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h0, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (rsp.pready !== 1'b1 && k < 50);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [14:0] idx, input logic [7:0] d);
    apb(1'b1, addr(idx), d);
  endtask : wr

  // Reads a register and compares the whole word with a clean response.
  task automatic rdchk(input logic [14:0] idx, input logic [7:0] e);
    apb(1'b0, addr(idx), 8'h00);
    `CHK(rd, {24'h0, e})
    `CHK(er, 1'b0)
  endtask : rdchk

  // Waits for a busy period and counts reads until it ends.
  task automatic sync(input logic try_hold, output int cnt);
    int k;
    cnt = 0;
    k = 0;
    do
    begin
      apb(1'b0, addr(I_HLD), 8'h00);
      k++;
    end
    while (rd[1] !== 1'b1 && k < 1500);
    if (try_hold)
    begin
      wr(I_HLD, 8'h01);
      apb(1'b0, addr(I_HLD), 8'h00);
      `CHK(rd[0], 1'b0)
    end
    do
    begin
      apb(1'b0, addr(I_HLD), 8'h00);
      cnt++;
    end
    while (rd[1] === 1'b1 && cnt < 100);
  endtask : sync

  task automatic summarize();
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    seed = 32'hb973;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, unmapped and misaligned accesses, stopped counters.
    rdchk(I_CTL, 8'h02);
    rdchk(I_HLD, 8'h00);
    rdchk(I_SEC, 8'h00);
    rdchk(I_MIN, 8'h00);
    rdchk(I_HR, 8'h12);
    rdchk(I_DAY, 8'h01);
    apb(1'b0, addr(15'h5148), 8'h00);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b1, addr(I_SEC) | 17'h1, 8'h33);
    `CHK(er, 1'b1)
    repeat (SEC + 100) @(posedge mclk);
    rdchk(I_SEC, 8'h00);
    $display("test reset_map done");
    // Random legal values with reserved bits set are loaded and read back.
    for (int i = 0; i < 4; i++)
    begin
      v = bcd($unsigned($random(seed)) % 60);
      wr(I_SEC, v | 8'h80);
      rdchk(I_SEC, v);
      v = bcd($unsigned($random(seed)) % 60);
      wr(I_MIN, v | 8'h80);
      rdchk(I_MIN, v);
      v = bcd(1 + $unsigned($random(seed)) % 12) | {1'b0, seed[3], 6'h0};
      wr(I_HR, v | 8'h80);
      rdchk(I_HR, v);
      v = bcd(1 + $unsigned($random(seed)) % 28);
      wr(I_DAY, v | 8'hc0);
      rdchk(I_DAY, v);
    end
    $display("test readback done");
    // 11:59:58 PM on the last day rolls to 12:00:00 AM, day 01.
    wr(I_HR, 8'h51);
    wr(I_MIN, 8'h59);
    wr(I_SEC, 8'h58);
    wr(I_DAY, 8'h31);
    wr(I_CTL, 8'h01);
    repeat (2 * SEC + 60) @(posedge mclk);
    rdchk(I_SEC, 8'h00);
    rdchk(I_MIN, 8'h00);
    rdchk(I_HR, 8'h12);
    rdchk(I_DAY, 8'h01);
    `CHK(mc_cnt, 1)
    $display("test rollover_12h done");
    // Format change keeps hours and meridian until the next hour update.
    sync(1'b0, n);
    wr(I_CTL, 8'h02);
    wr(I_HR, 8'h49);
    wr(I_CTL, 8'h12);
    rdchk(I_HR, 8'h49);
    wr(I_MIN, 8'h59);
    wr(I_SEC, 8'h59);
    wr(I_DAY, 8'h05);
    wr(I_CTL, 8'h10);
    sync(1'b0, n);
    rdchk(I_HR, 8'h10);
    wr(I_HR, 8'h63);
    rdchk(I_HR, 8'h23);
    wr(I_MIN, 8'h59);
    wr(I_SEC, 8'h59);
    // A short month ends on day 05, so the day rolls over again.
    last_day <= 6'h05;
    sync(1'b0, n);
    rdchk(I_HR, 8'h00);
    rdchk(I_DAY, 8'h01);
    `CHK(mc_cnt, 2)
    $display("test format_24h done");
    // Busy length and refused hold during busy.
    sync(1'b0, n);
    `CHK(n inside {2, 3}, 1'b1)
    sync(1'b1, n);
    $display("test busy done");
    // Hold blocks seconds, one second is added on release.
    sync(1'b0, n);
    wr(I_SEC, 8'h25);
    wr(I_HLD, 8'h01);
    rdchk(I_HLD, 8'h01);
    repeat (2 * SEC + SEC / 2) @(posedge mclk);
    rdchk(I_SEC, 8'h25);
    wr(I_HLD, 8'h00);
    rdchk(I_HLD, 8'h02);
    repeat (20) @(posedge mclk);
    rdchk(I_SEC, 8'h26);
    $display("test hold done");
    // Thirty-second adjust, upper and lower half of the minute.
    for (int j = 0; j < 2; j++)
    begin
      sync(1'b0, n);
      wr(I_MIN, 8'h10);
      wr(I_SEC, bcd(30 * j + $unsigned($random(seed)) % 30));
      wr(I_CTL, 8'h14);
      rdchk(I_CTL, 8'h14);
      repeat (30) @(posedge mclk);
      rdchk(I_CTL, 8'h10);
      rdchk(I_SEC, 8'h00);
      rdchk(I_MIN, 8'h10 + 8'(j));
    end
    $display("test adjust done");
    // Soft reset clears hold, self clears and restarts the divider.
    wr(I_SEC, 8'h30);
    wr(I_HLD, 8'h01);
    wr(I_CTL, 8'h11);
    rdchk(I_HLD, 8'h00);
    rdchk(I_CTL, 8'h10);
    repeat (SEC - 80) @(posedge mclk);
    rdchk(I_SEC, 8'h30);
    repeat (100) @(posedge mclk);
    rdchk(I_SEC, 8'h31);
    $display("test soft_reset done");
    summarize();
  end
endmodule : rtcc_time_counters_tb_top
